// >>> hw/quad_enc_counter.v
/*
 Quadrature encoder counter: scaled 16.16 position accumulation, index
 event latching and clearing, deviation check and event flags.
 Assumes a register port fed by the serial host interface, one core clock,
 and the encoder feeding A, B and index on plain inputs.
*/
// Operation
// - Encoder counting stops while step/direction mode is selected.
// - Encoder position is a 32-bit signed register, readable and writable.
// - Scale constant is signed 16.16 fixed point.
// - Each count adds or subtracts the constant; fraction carries past denominator.
// - Config bit 10 picks denominator 65536 (clear) or 10000 (set).
// - Software picks the constant's sign to match motor rotation.
// - Flags: bit 0 index event, bit 1 deviation; write one clears.
// - Deviation flag cannot be cleared while the deviation persists.
// - Both flags are ORed onto the interrupt output.
// - Qualifying index event, with bit 4 or armed bit 5 set, copies position into the captured register.
// - Deviation warns when count and ramp differ by more than the 20-bit limit; zero disables.
// - Config bit 9 also latches the ramp actual position on index.
// - Config bit 8 clear latches only; set latches then clears the counter.
// - Bits 7:6 pick level, active edge, inactive edge or both edges.
// - Bit 5 acts only on the first index event after the config write.
// - Bit 4 acts on every index event.
// - Bit 3 clear needs A, B and index polarities; set ignores A and B.
// - Bit 2 sets index active level: 0 low, 1 high.
// - Bits 0 and 1 give required A and B levels.
`timescale 1ns/10ps
`include "quad_enc_defs.vh"

module quad_enc_counter
#(
	parameter LIMIT_WIDTH = 20
)
(
	// Clock and reset
	input wire core_clk_in,
	input wire rst_n_in,
	// Register port behind the serial host interface
	input wire [6:0] reg_addr_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [31:0] reg_wdata_in,
	output reg [31:0] reg_rdata_out,
	// Encoder lines
	input wire enc_a_in,
	input wire enc_b_in,
	input wire enc_n_in,
	// Motion controller context
	input wire step_dir_mode_in,
	input wire [31:0] ramp_actual_position_in,
	output reg [31:0] ramp_captured_position_out,
	output reg ramp_capture_pulse_out,
	// Interrupt
	output wire interrupt_out
);

// ****************************************************************
// Registers
// ****************************************************************
reg [10:0] encoder_config_r;
reg [31:0] encoder_position_r;
reg [31:0] encoder_scale_constant_r;
reg [1:0] encoder_event_flags_r;
reg [31:0] encoder_captured_position_r;
reg [LIMIT_WIDTH-1:0] encoder_mismatch_limit_r;
reg [15:0] frac_acc_r;
reg once_armed_r;
reg qual_prev_r;

reg [31:0] position_nxt;
reg [15:0] frac_nxt;
reg [31:0] rdata_nxt;

wire a_level;
wire b_level;
wire n_level;
wire count_up;
wire count_down;

// ****************************************************************
// Decoder
// ****************************************************************
quad_decoder u_decoder
(
	.core_clk_in(core_clk_in),
	.rst_n_in(rst_n_in),
	.enc_a_in(enc_a_in),
	.enc_b_in(enc_b_in),
	.enc_n_in(enc_n_in),
	.a_level_out(a_level),
	.b_level_out(b_level),
	.n_level_out(n_level),
	.count_up_out(count_up),
	.count_down_out(count_down)
);

// ****************************************************************
// Register write decode
// ****************************************************************
wire wr_config = reg_wr_in && (reg_addr_in == `ADDR_ENCODER_CONFIG);
wire wr_position = reg_wr_in && (reg_addr_in == `ADDR_ENCODER_POSITION);
wire wr_constant = reg_wr_in && (reg_addr_in == `ADDR_ENCODER_SCALE_CONSTANT);
wire wr_flags = reg_wr_in && (reg_addr_in == `ADDR_ENCODER_EVENT_FLAGS);
wire wr_limit = reg_wr_in && (reg_addr_in == `ADDR_ENCODER_MISMATCH_LIMIT);

// ****************************************************************
// Index qualification and sensitivity
// ****************************************************************
wire pol_a = encoder_config_r[`CFG_POL_A];
wire pol_b = encoder_config_r[`CFG_POL_B];
wire pol_n = encoder_config_r[`CFG_POL_N];
wire skip_quadrature_qualify = encoder_config_r[`CFG_SKIP_QUAD_QUALIFY];
wire pos_edge = encoder_config_r[`CFG_POS_EDGE];
wire neg_edge = encoder_config_r[`CFG_NEG_EDGE];
wire sel_decimal = encoder_config_r[`CFG_SEL_DECIMAL];

wire ab_match = skip_quadrature_qualify || ((a_level == pol_a) && (b_level == pol_b));
wire index_qual = (n_level == pol_n) && ab_match;

reg index_event;
always @*
begin
	case ({neg_edge, pos_edge})
		2'h0: index_event = index_qual;
		2'h1: index_event = index_qual && !qual_prev_r;
		2'h2: index_event = !index_qual && qual_prev_r;
		2'h3: index_event = index_qual != qual_prev_r;
		default: index_event = 1'b0;
	endcase
end

// Index events are meaningless while the pins serve step/direction
wire index_hit = index_event && !step_dir_mode_in;
wire action_enabled = encoder_config_r[`CFG_CLR_CONT] ||
	(encoder_config_r[`CFG_CLR_ONCE] && once_armed_r);
wire index_action = index_hit && action_enabled;
wire index_clear = index_action && encoder_config_r[`CFG_CLR_ENC_X];

// ****************************************************************
// Scaled accumulation
// ****************************************************************
wire [17:0] frac_mod = sel_decimal ? `FRAC_MOD_DECIMAL : `FRAC_MOD_BINARY;
wire [31:0] int_step = {{16{encoder_scale_constant_r[31]}}, encoder_scale_constant_r[31:16]};
wire [17:0] frac_step = {2'h0, encoder_scale_constant_r[15:0]};
wire [17:0] frac_up = {2'h0, frac_acc_r} + frac_step;
wire [17:0] frac_down = {2'h0, frac_acc_r} - frac_step;
wire [17:0] frac_up_wrap = frac_up - frac_mod;
wire [17:0] frac_down_wrap = frac_down + frac_mod;
wire up_carry = frac_up >= frac_mod;
wire down_borrow = frac_down[17];
wire count_active = !step_dir_mode_in;

always @*
begin
	position_nxt = encoder_position_r;
	frac_nxt = frac_acc_r;
	if (wr_position)
	begin
		position_nxt = reg_wdata_in;
		frac_nxt = 16'h0000;
	end
	else if (index_clear)
	begin
		position_nxt = 32'h00000000;
		frac_nxt = 16'h0000;
	end
	else if (count_active && count_up)
	begin
		// Carry folds the excess fraction back below the denominator
		frac_nxt = up_carry ? frac_up_wrap[15:0] : frac_up[15:0];
		position_nxt = encoder_position_r + int_step + {31'h00000000, up_carry};
	end
	else if (count_active && count_down)
	begin
		frac_nxt = down_borrow ? frac_down_wrap[15:0] : frac_down[15:0];
		position_nxt = encoder_position_r - int_step - {31'h00000000, down_borrow};
	end
end

// ****************************************************************
// Deviation check
// ****************************************************************
// Compared in 33 bits so a wrap of either position cannot hide a gap
wire [32:0] pos_diff = {encoder_position_r[31], encoder_position_r} -
	{ramp_actual_position_in[31], ramp_actual_position_in};
wire [32:0] pos_gap = pos_diff[32] ? (33'h000000000 - pos_diff) : pos_diff;
wire limit_on = encoder_mismatch_limit_r != {LIMIT_WIDTH{1'b0}};
wire deviation_now = limit_on && (pos_gap > {{(33-LIMIT_WIDTH){1'b0}}, encoder_mismatch_limit_r});

// ****************************************************************
// Sequential state: configuration registers
// ****************************************************************
always @(posedge core_clk_in or negedge rst_n_in)
begin
	if (!rst_n_in)
	begin
		encoder_config_r <= `RST_ENCODER_CONFIG;
		encoder_scale_constant_r <= `RST_ENCODER_SCALE_CONSTANT;
		encoder_mismatch_limit_r <= {LIMIT_WIDTH{1'b0}};
	end
	else
	begin
		if (wr_config)
			encoder_config_r <= reg_wdata_in[10:0];
		if (wr_constant)
			encoder_scale_constant_r <= reg_wdata_in;
		if (wr_limit)
			encoder_mismatch_limit_r <= reg_wdata_in[LIMIT_WIDTH-1:0];
	end
end

// ****************************************************************
// Sequential state: position, fraction, index history and read data
// ****************************************************************
always @(posedge core_clk_in or negedge rst_n_in)
begin
	if (!rst_n_in)
	begin
		encoder_position_r <= `RST_ENCODER_POSITION;
		frac_acc_r <= 16'h0000;
		qual_prev_r <= 1'b0;
		reg_rdata_out <= 32'h00000000;
	end
	else
	begin
		qual_prev_r <= index_qual;
		encoder_position_r <= position_nxt;
		frac_acc_r <= frac_nxt;
		reg_rdata_out <= rdata_nxt;
	end
end

// ****************************************************************
// Index action: arming, position capture and ramp capture
// ****************************************************************
always @(posedge core_clk_in or negedge rst_n_in)
begin
	if (!rst_n_in)
	begin
		once_armed_r <= 1'b0;
		encoder_captured_position_r <= 32'h00000000;
		ramp_captured_position_out <= 32'h00000000;
		ramp_capture_pulse_out <= 1'b0;
	end
	else
	begin
		ramp_capture_pulse_out <= 1'b0;
		// A config write re-arms the single-shot action
		if (wr_config)
			once_armed_r <= 1'b1;
		else if (index_action)
			once_armed_r <= 1'b0;
		if (index_action)
		begin
			// Captured value is the position before a same-cycle clear
			encoder_captured_position_r <= encoder_position_r;
			if (encoder_config_r[`CFG_LATCH_RAMP])
			begin
				ramp_captured_position_out <= ramp_actual_position_in;
				ramp_capture_pulse_out <= 1'b1;
			end
		end
	end
end

// ****************************************************************
// Event flags
// ****************************************************************
always @(posedge core_clk_in or negedge rst_n_in)
begin
	if (!rst_n_in)
		encoder_event_flags_r <= 2'h0;
	else
	begin
		// Set wins over the write-one clear, so no event is lost to a clear
		encoder_event_flags_r[`FLAG_INDEX_EVENT] <= index_hit ||
			(encoder_event_flags_r[`FLAG_INDEX_EVENT] &&
			!(wr_flags && reg_wdata_in[`FLAG_INDEX_EVENT]));
		encoder_event_flags_r[`FLAG_DEVIATION] <= deviation_now ||
			(encoder_event_flags_r[`FLAG_DEVIATION] &&
			!(wr_flags && reg_wdata_in[`FLAG_DEVIATION]));
	end
end

// ****************************************************************
// Read mux; write-only registers and unmapped offsets read zero
// ****************************************************************
always @*
begin
	rdata_nxt = reg_rdata_out;
	if (reg_rd_in)
	begin
		case (reg_addr_in)
			`ADDR_ENCODER_CONFIG: rdata_nxt = {21'h000000, encoder_config_r};
			`ADDR_ENCODER_POSITION: rdata_nxt = encoder_position_r;
			`ADDR_ENCODER_EVENT_FLAGS: rdata_nxt = {30'h00000000, encoder_event_flags_r};
			`ADDR_ENCODER_CAPTURED_POSITION: rdata_nxt = encoder_captured_position_r;
			default: rdata_nxt = 32'h00000000;
		endcase
	end
end

assign interrupt_out = |encoder_event_flags_r;

endmodule // quad_enc_counter

// >>> hw/quad_enc_defs.vh
/*
 Register offsets, configuration field positions and reset values of the
 quadrature encoder counter. Assumes inclusion by bare name, definitions only.
*/
`ifndef QUAD_ENC_DEFS_VH
`define QUAD_ENC_DEFS_VH

// ****************************************************************
// Register offsets on the 7-bit internal register port
// ****************************************************************
`define ADDR_ENCODER_CONFIG 7'h38
`define ADDR_ENCODER_POSITION 7'h39
`define ADDR_ENCODER_SCALE_CONSTANT 7'h3A
`define ADDR_ENCODER_EVENT_FLAGS 7'h3B
`define ADDR_ENCODER_CAPTURED_POSITION 7'h3C
`define ADDR_ENCODER_MISMATCH_LIMIT 7'h3D

// ****************************************************************
// Configuration field positions
// ****************************************************************
`define CFG_POL_A 0
`define CFG_POL_B 1
`define CFG_POL_N 2
`define CFG_SKIP_QUAD_QUALIFY 3
`define CFG_CLR_CONT 4
`define CFG_CLR_ONCE 5
`define CFG_POS_EDGE 6
`define CFG_NEG_EDGE 7
`define CFG_CLR_ENC_X 8
`define CFG_LATCH_RAMP 9
`define CFG_SEL_DECIMAL 10

// ****************************************************************
// Status flag positions
// ****************************************************************
`define FLAG_INDEX_EVENT 0
`define FLAG_DEVIATION 1

// ****************************************************************
// Reset values and fraction moduli
// ****************************************************************
`define RST_ENCODER_CONFIG 11'h000
`define RST_ENCODER_POSITION 32'h00000000
`define RST_ENCODER_SCALE_CONSTANT 32'h00010000
`define RST_ENCODER_MISMATCH_LIMIT 20'h00000
`define FRAC_MOD_BINARY 18'h10000
`define FRAC_MOD_DECIMAL 18'h02710

`endif

// >>> hw/quad_decoder.v
/*
 Synchronises the A, B and index lines and turns each valid quadrature
 transition into a one-cycle up or down pulse.
 Assumes the encoder edges are slow against the core clock.
*/
`timescale 1ns/10ps

module quad_decoder
(
	// Clock and reset
	input wire core_clk_in,
	input wire rst_n_in,
	// Encoder lines
	input wire enc_a_in,
	input wire enc_b_in,
	input wire enc_n_in,
	// Decoded outputs
	output wire a_level_out,
	output wire b_level_out,
	output wire n_level_out,
	output reg count_up_out,
	output reg count_down_out
);

reg [2:0] meta_r;
reg [2:0] sync_r;
reg [1:0] prev_ab_r;
wire [1:0] cur_ab;
wire up_step;
wire down_step;

assign cur_ab = sync_r[1:0];
assign a_level_out = sync_r[0];
assign b_level_out = sync_r[1];
assign n_level_out = sync_r[2];

// ****************************************************************
// Gray sequence 00-01-11-10 (bit0 = A) counts up; both bits moving is dropped
// ****************************************************************
assign up_step = (prev_ab_r == 2'h0 && cur_ab == 2'h1) || (prev_ab_r == 2'h1 && cur_ab == 2'h3) ||
	(prev_ab_r == 2'h3 && cur_ab == 2'h2) || (prev_ab_r == 2'h2 && cur_ab == 2'h0);
assign down_step = (prev_ab_r == 2'h1 && cur_ab == 2'h0) || (prev_ab_r == 2'h3 && cur_ab == 2'h1) ||
	(prev_ab_r == 2'h2 && cur_ab == 2'h3) || (prev_ab_r == 2'h0 && cur_ab == 2'h2);

always @(posedge core_clk_in or negedge rst_n_in)
begin
	if (!rst_n_in)
	begin
		meta_r <= 3'h0;
		sync_r <= 3'h0;
		prev_ab_r <= 2'h0;
		count_up_out <= 1'b0;
		count_down_out <= 1'b0;
	end
	else
	begin
		meta_r <= {enc_n_in, enc_b_in, enc_a_in};
		sync_r <= meta_r;
		prev_ab_r <= cur_ab;
		count_up_out <= up_step;
		count_down_out <= down_step;
	end
end

endmodule // quad_decoder

// >>> dv/quad_enc_counter_assertions.sv
/*
 Port checker of the encoder counter.
 Assumes a bind onto quad_enc_counter.
*/
`timescale 1ns/10ps
module quad_enc_counter_assertions
#(
	parameter LIMIT_WIDTH = 20
)
(
	// Clock and reset
	input wire core_clk_in,
	input wire rst_n_in,
	// Register port
	input wire [6:0] reg_addr_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [31:0] reg_wdata_in,
	input wire [31:0] reg_rdata_out,
	// Encoder and context
	input wire enc_a_in,
	input wire enc_b_in,
	input wire enc_n_in,
	input wire step_dir_mode_in,
	input wire [31:0] ramp_actual_position_in,
	input wire [31:0] ramp_captured_position_out,
	input wire ramp_capture_pulse_out,
	input wire interrupt_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	// ****************
	// Register port
	// ****************
	wire rd_hole = reg_rd_in && (reg_addr_in < 7'h38 || reg_addr_in > 7'h3D);
	wire rd_wo = reg_rd_in && (reg_addr_in == 7'h3A || reg_addr_in == 7'h3D);
	a_unmapped_zero: assert property (rd_hole |=> reg_rdata_out == 32'h0)
		else $error("Unmapped read not zero");
	a_wo_reads_zero: assert property (rd_wo |=> reg_rdata_out == 32'h0)
		else $error("Write-only read not zero");
	a_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
		else $error("Read data moved without a read");
	a_cfg_readback: assert property ((reg_wr_in && reg_addr_in == 7'h38) ##1 !reg_wr_in ##1
		(reg_rd_in && !reg_wr_in && reg_addr_in == 7'h38) |=>
		reg_rdata_out == {21'h0, $past(reg_wdata_in[10:0], 3)})
		else $error("Config readback wrong");
	// Frozen counting makes the written position exact
	a_pos_readback: assert property ((reg_wr_in && reg_addr_in == 7'h39 && step_dir_mode_in)
		##1 (!reg_wr_in && step_dir_mode_in)
		##1 (reg_rd_in && !reg_wr_in && reg_addr_in == 7'h39 && step_dir_mode_in)
		|=> reg_rdata_out == $past(reg_wdata_in, 3))
		else $error("Position readback wrong");
	a_flags_irq: assert property ((reg_rd_in && reg_addr_in == 7'h3B) |=>
		reg_rdata_out[31:2] == 30'h0 && (|reg_rdata_out[1:0]) == $past(interrupt_out))
		else $error("Flags and interrupt disagree");
	// ****************
	// Ramp capture
	// ****************
	a_ramp_value: assert property (ramp_capture_pulse_out |->
		ramp_captured_position_out == $past(ramp_actual_position_in))
		else $error("Ramp capture value wrong");
	a_ramp_hold: assert property (!ramp_capture_pulse_out |->
		$stable(ramp_captured_position_out))
		else $error("Ramp capture moved without pulse");
	a_stepdir_freeze: assert property (step_dir_mode_in [*4] |-> !ramp_capture_pulse_out)
		else $error("Index action in step mode");
	c_ramp: cover property (ramp_capture_pulse_out);
	c_irq: cover property (interrupt_out);
	c_sdm_wr: cover property (step_dir_mode_in && reg_wr_in);
endmodule // quad_enc_counter_assertions

bind quad_enc_counter quad_enc_counter_assertions #(.LIMIT_WIDTH(LIMIT_WIDTH)) u_chk (
	.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
	.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
	.reg_rdata_out(reg_rdata_out), .enc_a_in(enc_a_in), .enc_b_in(enc_b_in),
	.enc_n_in(enc_n_in), .step_dir_mode_in(step_dir_mode_in),
	.ramp_actual_position_in(ramp_actual_position_in),
	.ramp_captured_position_out(ramp_captured_position_out),
	.ramp_capture_pulse_out(ramp_capture_pulse_out), .interrupt_out(interrupt_out));

// >>> dv/quad_enc_model.sv
/*
 Behavioural A/B/index encoder for the counter bench.
 Assumes its tasks are called from one process.
*/
`timescale 1ns/10ps
module quad_enc_model
(
	// Clock
	input wire core_clk_in,
	// Encoder lines
	output reg enc_a_out,
	output reg enc_b_out,
	output reg enc_n_out
);
	reg [1:0] phase_r;
	initial
	begin
		phase_r = 2'h0;
		enc_a_out = 1'b0;
		enc_b_out = 1'b0;
		enc_n_out = 1'b0;
	end
	// Gray order 00, 01, 11, 10 with A in bit 0; spacing beats the sync delay
	task move(input integer n, input up);
		integer k;
	begin
		for (k = 0; k < n; k = k + 1)
		begin
			@(posedge core_clk_in);
			phase_r = up ? phase_r + 2'h1 : phase_r - 2'h1;
			enc_a_out <= phase_r[0] ^ phase_r[1];
			enc_b_out <= phase_r[1];
			repeat (5) @(posedge core_clk_in);
		end
		repeat (2) @(posedge core_clk_in);
	end
	endtask
	task index;
	begin
		@(posedge core_clk_in);
		enc_n_out <= 1'b1;
		repeat (6) @(posedge core_clk_in);
		enc_n_out <= 1'b0;
		repeat (6) @(posedge core_clk_in);
	end
	endtask
endmodule // quad_enc_model

// >>> dv/quad_enc_counter_tb.sv
/*
 Self-checking bench of the encoder counter.
 Assumes the encoder model and the bound checker.
*/
`timescale 1ns/10ps
module quad_enc_counter_tb;
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	reg [6:0] addr = 7'h00;
	reg wr = 1'b0;
	reg rd = 1'b0;
	reg [31:0] wdata = 32'h0;
	reg sdm = 1'b0;
	reg [31:0] ramp = 32'h0;
	wire [31:0] rdata;
	wire [31:0] ramp_cap;
	wire ramp_pulse;
	wire irq;
	wire enc_a;
	wire enc_b;
	wire enc_n;
	integer n_mismatch = 0;
	integer total_checks = 0;
	integer i;
	always #2 clk = ~clk;
	quad_enc_model u_enc (.core_clk_in(clk), .enc_a_out(enc_a), .enc_b_out(enc_b),
		.enc_n_out(enc_n));
	quad_enc_counter #(.LIMIT_WIDTH(20)) u_dut (.core_clk_in(clk), .rst_n_in(rst_n),
		.reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .enc_a_in(enc_a), .enc_b_in(enc_b), .enc_n_in(enc_n),
		.step_dir_mode_in(sdm), .ramp_actual_position_in(ramp),
		.ramp_captured_position_out(ramp_cap), .ramp_capture_pulse_out(ramp_pulse),
		.interrupt_out(irq));
	task chk(input [31:0] got, input [31:0] exp);
	begin
		total_checks = total_checks + 1;
		if (got !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task wr_reg(input [6:0] a, input [31:0] d);
	begin
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	end
	endtask
	task rd_reg(input [6:0] a, input [31:0] e);
	begin
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	end
	endtask
	task conclude;
	begin
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	// Whole run needs about 330 cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch = n_mismatch + 1;
		$display("watchdog expired");
		conclude;
	end
	initial
	begin
		repeat (16) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rst_n <= 1'b1;
		// Reset config wants index, A and B low: idle lines make a level event
		for (i = 0; i < 7; i = i + 1)
			rd_reg(7'h38 + i[6:0], (i == 3) ? 32'h1 : 32'h0);
		chk({31'h0, irq}, 32'h1);
		$display("test reset done");
		u_enc.move(4, 1'b1);
		rd_reg(7'h39, 32'h00000004);
		u_enc.move(6, 1'b0);
		rd_reg(7'h39, 32'hFFFFFFFE);
		@(posedge clk) sdm <= 1'b1;
		u_enc.move(3, 1'b1);
		rd_reg(7'h39, 32'hFFFFFFFE);
		wr_reg(7'h39, 32'h12345678);
		rd_reg(7'h39, 32'h12345678);
		wr_reg(7'h39, 32'h0);
		@(posedge clk) sdm <= 1'b0;
		$display("test counting done");
		wr_reg(7'h3A, 32'h00018000);
		u_enc.move(2, 1'b1);
		rd_reg(7'h39, 32'h00000003);
		wr_reg(7'h38, 32'h00000400);
		rd_reg(7'h38, 32'h00000400);
		wr_reg(7'h3A, 32'h00011388);
		u_enc.move(2, 1'b1);
		rd_reg(7'h39, 32'h00000006);
		$display("test scaling done");
		@(posedge clk) ramp <= 32'h00001234;
		wr_reg(7'h39, 32'h00000020);
		wr_reg(7'h38, 32'h0000025C);
		u_enc.index;
		rd_reg(7'h3C, 32'h00000020);
		rd_reg(7'h39, 32'h00000020);
		rd_reg(7'h3B, 32'h00000001);
		chk({31'h0, irq}, 32'h1);
		chk(ramp_cap, 32'h00001234);
		wr_reg(7'h3B, 32'h00000001);
		rd_reg(7'h3B, 32'h0);
		wr_reg(7'h38, 32'h0000015C);
		u_enc.index;
		rd_reg(7'h39, 32'h0);
		wr_reg(7'h39, 32'h00000005);
		u_enc.index;
		rd_reg(7'h3C, 32'h00000005);
		wr_reg(7'h38, 32'h0000016C);
		wr_reg(7'h39, 32'h00000007);
		u_enc.index;
		rd_reg(7'h39, 32'h0);
		wr_reg(7'h39, 32'h00000009);
		u_enc.index;
		rd_reg(7'h39, 32'h00000009);
		rd_reg(7'h3C, 32'h00000007);
		$display("test index done");
		@(posedge clk) ramp <= 32'h00000009;
		wr_reg(7'h3B, 32'h00000003);
		wr_reg(7'h3D, 32'h00000002);
		@(posedge clk) ramp <= 32'h0000000C;
		rd_reg(7'h3B, 32'h00000002);
		wr_reg(7'h3B, 32'h00000002);
		rd_reg(7'h3B, 32'h00000002);
		@(posedge clk) ramp <= 32'h0000000B;
		wr_reg(7'h3B, 32'h00000002);
		rd_reg(7'h3B, 32'h0);
		chk({31'h0, irq}, 32'h0);
		$display("test deviation done");
		wr_reg(7'h3D, 32'h00000000);
		wr_reg(7'h38, 32'h00000195);
		wr_reg(7'h39, 32'h00000033);
		u_enc.index;
		rd_reg(7'h39, 32'h0);
		rd_reg(7'h3C, 32'h00000033);
		wr_reg(7'h3B, 32'h00000001);
		wr_reg(7'h38, 32'h00000197);
		wr_reg(7'h39, 32'h00000044);
		u_enc.index;
		rd_reg(7'h39, 32'h00000044);
		rd_reg(7'h3B, 32'h0);
		$display("test qualify done");
		conclude;
	end
endmodule // quad_enc_counter_tb
